// ==== logic/adc_dc_level_measurement.sv ====
// DC level meter for the mono record ADC channel
//
// What this block does
// RULE1: Measure only while enable bit is set
// RULE2: Filter bit picks sinc averager or IIR
// RULE3: Software writes averaging exponent 1 to 20 only
// RULE4: Freeze bit stops refreshing the result
// RULE5: Result select: instantaneous or pre-clear IIR value
// RULE6: IIR code zero infinite, else clear every 2^n
// RULE7: Result spread over three read-only bytes
// RULE8: Sinc refreshes all bytes once per block
`include "dc_meas_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_dc_level_measurement
    import dc_meas_pkg::*;
#(
    parameter int DATA_W  = 24,
    parameter int MAX_EXP = `DC_MAX_EXP
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [6:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    output var  logic [7:0]        reg_rdata,
    input  wire logic              adc_valid,
    input  wire logic [DATA_W-1:0] adc_data
);

    localparam int ACC_W = DATA_W + `DC_FRAC_BITS;

    if (DATA_W != 24 || MAX_EXP != 20 || MAX_EXP > `DC_FRAC_BITS) begin : g_chk
        $error("Unsupported width or exponent range");
    end

    // Mask of 2^n - 1; codes above the limit saturate
    function automatic logic [19:0] span_mask(input logic [4:0] n);
        logic [4:0] m;
        m = (n > 5'(MAX_EXP)) ? 5'(MAX_EXP) : n;
        return 20'((21'h1 << m) - 21'h1);
    endfunction

    // Exponent 1 to MAX_EXP; reserved codes fall back to the nearest legal
    function automatic logic [4:0] legal_exp(input logic [4:0] n);
        logic [4:0] m;
        m = (n == 5'h00) ? 5'h01 : n;
        return (m > 5'(MAX_EXP)) ? 5'(MAX_EXP) : m;
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0]  mode_cfg;
    logic [7:0]  iir_cfg;
    logic [23:0] result;

    wire wr_mode = reg_wr && (reg_addr == `DC_MODE_CONFIG_OFS);
    wire wr_iir  = reg_wr && (reg_addr == `DC_IIR_CONFIG_OFS);

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_cfg <= `DC_CFG_RESET;
            iir_cfg  <= `DC_CFG_RESET;
        end else begin
            if (wr_mode) begin
                mode_cfg <= reg_wdata;
            end
            if (wr_iir) begin
                iir_cfg <= reg_wdata;
            end
        end
    end

    wire        meas_en  = mode_cfg[`DC_MODE_ENABLE_BIT];
    wire        freeze   = iir_cfg[`DC_IIR_FREEZE_BIT];
    wire        held_sel = iir_cfg[`DC_IIR_HELD_BIT];
    wire [4:0]  sinc_exp = mode_cfg[`DC_EXP_MSB:`DC_EXP_LSB];
    wire [4:0]  iir_exp  = iir_cfg[`DC_EXP_MSB:`DC_EXP_LSB];
    wire filt_mode_t mode = mode_cfg[`DC_MODE_FILTER_BIT] ? FILT_IIR
                                                          : FILT_SINC; // RULE2

    // Code zero would be a pass-through; treat it as exponent one
    // since software must not use it for sinc mode
    wire [4:0]  sinc_d   = legal_exp(sinc_exp); // RULE3
    // Coefficient follows the mode exponent; the IIR code only sets
    // the clearing period
    wire [4:0]  iir_k    = sinc_d; // RULE2

    // ------------------------------------------------------------
    // Sinc averager
    // ------------------------------------------------------------
    logic signed [ACC_W-1:0] sinc_acc;
    logic [19:0]             sinc_cnt;

    wire signed [ACC_W-1:0] sample_ext = ACC_W'(signed'(adc_data));
    wire signed [ACC_W-1:0] sinc_sum   = sinc_acc + sample_ext;
    wire signed [ACC_W-1:0] sinc_shift = sinc_sum >>> sinc_d;
    wire sinc_run  = meas_en && (mode == FILT_SINC); // RULE1
    wire blk_done  = sinc_run && adc_valid
                  && (sinc_cnt == span_mask(sinc_d)); // RULE2

    always_ff @(posedge clk) begin
        // A new exponent restarts the block so the count never overshoots
        if (srst || !sinc_run || wr_mode) begin
            sinc_acc <= '0;
            sinc_cnt <= '0;
        end else if (adc_valid) begin
            sinc_acc <= blk_done ? '0 : sinc_sum;
            sinc_cnt <= blk_done ? '0 : sinc_cnt + 20'h0_0001;
        end
    end

    // ------------------------------------------------------------
    // Low-pass IIR with periodic clearing
    // ------------------------------------------------------------
    logic signed [ACC_W-1:0] iir_acc;
    logic [19:0]             per_cnt;
    logic [23:0]             iir_held;

    wire iir_run  = meas_en && (mode == FILT_IIR); // RULE1
    wire iir_wrap = iir_run && (iir_exp != 5'h00)
                 && (per_cnt >= span_mask(iir_exp)); // RULE6
    wire signed [ACC_W-1:0] iir_target = sample_ext <<< `DC_FRAC_BITS;
    wire signed [ACC_W-1:0] iir_step   = (iir_target - iir_acc) >>> iir_k;
    wire signed [ACC_W-1:0] iir_next   = adc_valid ? iir_acc + iir_step
                                                   : iir_acc;
    wire [23:0] iir_out = 24'(iir_acc >>> `DC_FRAC_BITS);

    always_ff @(posedge clk) begin
        if (srst || !iir_run) begin
            iir_acc  <= '0;
            per_cnt  <= '0;
            iir_held <= `DC_RESULT_RESET;
        end else begin
            // Held value is what the filter reached just before clearing
            iir_acc  <= iir_wrap ? '0 : iir_next; // RULE6
            per_cnt  <= iir_wrap ? '0 : per_cnt + 20'h0_0001;
            if (iir_wrap) begin
                iir_held <= iir_out; // RULE5
            end
        end
    end

    // ------------------------------------------------------------
    // Result and read port
    // ------------------------------------------------------------
    wire [23:0] iir_pick    = held_sel ? iir_held : iir_out; // RULE5
    wire        take_sinc   = blk_done && !freeze; // RULE4
    wire        take_iir    = iir_run && !freeze; // RULE4
    wire [23:0] next_result = take_sinc ? 24'(sinc_shift)
                            : take_iir  ? iir_pick : result; // RULE8

    // Unmapped addresses read zero; 0x67 reads the high result byte
    wire [7:0] next_rdata =
        (reg_addr == `DC_MODE_CONFIG_OFS) ? mode_cfg
      : (reg_addr == `DC_RESULT_HIGH_OFS) ? result[23:16] // RULE7
      : (reg_addr == `DC_RESULT_MID_OFS)  ? result[15:8]
      : (reg_addr == `DC_RESULT_LOW_OFS)  ? result[7:0]
      : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            result    <= `DC_RESULT_RESET; // RULE7
            reg_rdata <= 8'h00;
        end else begin
            result    <= next_result;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_disabled_hold: assert property (@(posedge clk) disable iff (srst) // RULE1
        !meas_en && !$past(meas_en) |=> $stable(result))
        else $error("Result moved while measurement disabled");

    a_sinc_count: assert property (@(posedge clk) disable iff (srst) // RULE2
        sinc_run |-> sinc_cnt <= span_mask(sinc_d))
        else $error("Sinc block counter ran past block length");

    a_freeze_hold: assert property (@(posedge clk) disable iff (srst) // RULE4
        freeze |=> $stable(result))
        else $error("Result refreshed while frozen");

    a_iir_instant: assert property (@(posedge clk) disable iff (srst) // RULE5
        iir_run && !freeze && !held_sel |=> result == $past(iir_out))
        else $error("Instantaneous IIR value not reported");

    a_iir_clear: assert property (@(posedge clk) disable iff (srst) // RULE6
        iir_wrap ##1 iir_run |-> iir_acc == '0 && per_cnt == '0)
        else $error("IIR not cleared at period end");

    a_infinite_avg: assert property (@(posedge clk) disable iff (srst) // RULE6
        iir_run && iir_exp == 5'h00 |=> iir_acc == $past(iir_next))
        else $error("Infinite average was cleared");

    a_mid_byte: assert property (@(posedge clk) disable iff (srst) // RULE7
        reg_addr == `DC_RESULT_MID_OFS |=> reg_rdata == $past(result[15:8]))
        else $error("Middle result byte read wrong");

    a_high_byte: assert property (@(posedge clk) disable iff (srst) // RULE7
        reg_addr == `DC_RESULT_HIGH_OFS
        |=> reg_rdata == $past(result[23:16]))
        else $error("High result byte read wrong");

    a_low_byte: assert property (@(posedge clk) disable iff (srst) // RULE7
        reg_addr == `DC_RESULT_LOW_OFS
        |=> reg_rdata == $past(result[7:0]))
        else $error("Low result byte read wrong");

    a_held_latch: assert property (@(posedge clk) disable iff (srst) // RULE5
        iir_wrap |=> iir_held == $past(iir_out))
        else $error("Held value not latched at clear");

    a_held_pick: assert property (@(posedge clk) disable iff (srst) // RULE5
        iir_run && !freeze && held_sel |=> result == $past(iir_held))
        else $error("Held IIR value not reported");

    a_sinc_refresh: assert property (@(posedge clk) disable iff (srst) // RULE8
        sinc_run && !$past(iir_run) && result != $past(result)
        |-> $past(blk_done))
        else $error("Sinc result changed outside block end");

endmodule

`default_nettype wire

// ==== logic/dc_meas_consts.svh ====
// Register offsets, field positions and reset values of the DC level meter
`ifndef DC_MEAS_CONSTS_SVH
`define DC_MEAS_CONSTS_SVH

`define DC_MODE_CONFIG_OFS   7'h66
`define DC_IIR_CONFIG_OFS    7'h67
`define DC_RESULT_HIGH_OFS   7'h67
`define DC_RESULT_MID_OFS    7'h68
`define DC_RESULT_LOW_OFS    7'h69

`define DC_CFG_RESET         8'h00
`define DC_RESULT_RESET      24'h00_0000

`define DC_MODE_ENABLE_BIT   7
`define DC_MODE_FILTER_BIT   5
`define DC_IIR_FREEZE_BIT    6
`define DC_IIR_HELD_BIT      5
`define DC_EXP_LSB           0
`define DC_EXP_MSB           4

`define DC_MAX_EXP           20
`define DC_FRAC_BITS         20

`endif

// ==== logic/dc_meas_pkg.sv ====
// Types shared by the DC level meter
package dc_meas_pkg;

    typedef enum logic [1:0] {
        FILT_SINC = 2'b01,
        FILT_IIR  = 2'b10
    } filt_mode_t;

endpackage

// ==== verification/adc_dc_level_measurement_tb.sv ====
// Self-checking bench for the DC level meter
`include "dc_meas_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_dc_level_measurement_tb
    import dc_meas_pkg::*;
;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic [6:0]         reg_addr = 7'h00;
    logic               reg_wr = 1'b0;
    logic [7:0]         reg_wdata = 8'h00;
    logic [7:0]         reg_rdata;
    logic               adc_valid = 1'b0;
    logic [23:0]        adc_data = 24'h00_0000;
    int                 bad_count = 0;
    int                 num_checks = 0;
    int                 seed = 32'h0ee9_c215;
    logic [23:0]        got;
    logic [23:0]        exp_r;
    logic signed [23:0] x;
    logic signed [47:0] sum;

    adc_dc_level_measurement dut (
        .clk       (clk),
        .srst      (srst),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .adc_valid (adc_valid),
        .adc_data  (adc_data)
    );

    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // Bus and sample tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 d = reg_rdata;
    endtask
    task automatic rd3(output logic [23:0] r);
        rd(`DC_RESULT_HIGH_OFS, r[23:16]);
        rd(`DC_RESULT_MID_OFS, r[15:8]);
        rd(`DC_RESULT_LOW_OFS, r[7:0]);
    endtask
    // Back to back samples; random ones when rnd is set
    task automatic feed(input int n, input logic [23:0] v, input bit rnd);
        sum = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            x = rnd ? 24'($random(seed)) : v;
            adc_valid <= 1'b1;
            adc_data <= x;
            sum = sum + x;
        end
        @(posedge clk);
        adc_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [23:0] avg(input logic signed [47:0] s, int d);
        return 24'(s >>> d);
    endfunction
    // Filter model: 20 fraction bits, starts from zero
    function automatic logic [23:0] iir_model(input logic signed [23:0] v,
                                              input int k, input int n);
        logic signed [43:0] acc;
        acc = '0;
        for (int i = 0; i < n; i++) begin
            acc = acc + (((44'(v) <<< `DC_FRAC_BITS) - acc) >>> k);
        end
        return 24'(acc >>> `DC_FRAC_BITS);
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        print_verdict;
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(`DC_MODE_CONFIG_OFS, got[7:0]);
        check({16'h0, got[7:0]}, 24'h00_0000);
        rd3(got);
        check(got, `DC_RESULT_RESET);
        rd(7'h70, got[7:0]);
        check({16'h0, got[7:0]}, 24'h00_0000);
        for (int d = 1; d <= 4; d++) begin
            wr(`DC_MODE_CONFIG_OFS, 8'(8'h80 | d));
            feed(1 << d, 24'h00_0000, 1'b1);
            rd3(got);
            exp_r = avg(sum, d);
            check(got, exp_r);
        end
        // Frozen result keeps the last block although a new one completes
        wr(`DC_IIR_CONFIG_OFS, 8'h44);
        feed(16, 24'h12_3456, 1'b0);
        rd3(got);
        check(got, exp_r);
        wr(`DC_IIR_CONFIG_OFS, 8'h04);
        feed(16, 24'h12_3456, 1'b0);
        rd3(got);
        check(got, 24'h12_3456);
        // Disabled meter ignores samples; result bytes are read-only
        wr(`DC_MODE_CONFIG_OFS, 8'h04);
        wr(`DC_RESULT_MID_OFS, 8'hff);
        feed(16, 24'hf0_0000, 1'b0);
        rd3(got);
        check(got, 24'h12_3456);
        // IIR with D = 1, cleared every 2^12 clocks
        wr(`DC_IIR_CONFIG_OFS, 8'h0c);
        wr(`DC_MODE_CONFIG_OFS, 8'ha1);
        feed(40, 24'h10_0000, 1'b0);
        rd3(got);
        exp_r = iir_model(24'h10_0000, 1, 40);
        check(got, exp_r);
        wr(`DC_IIR_CONFIG_OFS, 8'h2c);
        rd3(got);
        check(got, 24'h00_0000);
        feed(4200, 24'h10_0000, 1'b0);
        rd3(got);
        check(got, exp_r);
        // New level moves the filter but not the held value
        feed(40, 24'h08_0000, 1'b0);
        rd3(got);
        check(got, exp_r);
        // Code zero never clears, so the held value stays put
        wr(`DC_IIR_CONFIG_OFS, 8'h20);
        feed(4200, 24'h08_0000, 1'b0);
        rd3(got);
        check(got, exp_r);
        // Fresh filter with D = 3 on a negative level
        wr(`DC_IIR_CONFIG_OFS, 8'h00);
        wr(`DC_MODE_CONFIG_OFS, 8'h04);
        wr(`DC_MODE_CONFIG_OFS, 8'ha3);
        feed(40, 24'hf8_0000, 1'b0);
        rd3(got);
        check(got, iir_model(24'hf8_0000, 3, 40));
        print_verdict;
    end
endmodule
`default_nettype wire
